// ### hw/lpbc_pkg.sv
// package for the low-power dram command controller: map, encodings, timing
package lpbc_pkg;
  // device mode register addresses
  localparam logic [7:0] MA_REFRESH_BANK_MASK = 8'h10;
  localparam logic [7:0] MA_REFRESH_SEGMENT_MASK = 8'h11;
  localparam logic [7:0] MA_CAL_PATTERN_A = 8'h20;
  localparam logic [7:0] MA_CAL_PATTERN_B = 8'h28;
  localparam logic [7:0] MA_TRAINING_ENTER_A = 8'h29;
  localparam logic [7:0] MA_TRAINING_EXIT = 8'h2A;
  localparam logic [7:0] MA_TRAINING_ENTER_B = 8'h30;
  localparam logic [7:0] MA_SOFT_RESET = 8'h3F;
  // avalon register byte offsets of the controller
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_WDATA = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BANK_LSB = 4;
  localparam int CMD_MASK_LSB = 8;
  localparam int CMD_AB_BIT = 12;
  localparam int CMD_GO_BIT = 31;
  localparam logic [3:0] OP_ACT = 4'h1;
  localparam logic [3:0] OP_RD = 4'h2;
  localparam logic [3:0] OP_WR = 4'h3;
  localparam logic [3:0] OP_PRE = 4'h4;
  localparam logic [3:0] OP_MRW = 4'h5;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;
  // ca-bus encodings on the rising edge
  localparam logic [3:0] CA_ACT = 4'b0010;
  localparam logic [3:0] CA_RD = 4'b0101;
  localparam logic [3:0] CA_WR = 4'b0001;
  localparam logic [3:0] CA_PRE = 4'b1011;
  localparam logic [3:0] CA_MRW = 4'b0000;
  localparam int NUM_BANKS = 8;
  localparam int BL = 8;
  localparam int FAW_ACTS = 4;
  localparam int SEG_LSB = 11;
  // link clocks in device clocks: must respect all time figures below
  localparam int RL = 10;
  localparam int WL = 6;
  localparam int SYS_PS = 8000;
  localparam int TRCD_PS = 18000;
  localparam int TRC_PS = 60000;
  localparam int TRRD_PS = 10000;
  localparam int TFAW_PS = 50000;
  localparam int TRPPB_PS = 18000;
  localparam int TRPAB_PS = 21000;
  localparam int TWR_PS = 15000;
  localparam int TWTR_PS = 7500;
  localparam int TDQSCK_PS = 5500;
  localparam int TCK_PS = 1500;
  function automatic int ru(input int t);
    return (t + TCK_PS - 1) / TCK_PS;
  endfunction
  localparam int C_RCD = ru(TRCD_PS);
  localparam int C_RC = ru(TRC_PS);
  localparam int C_RRD = ru(TRRD_PS);
  localparam int C_FAW = ru(TFAW_PS);
  localparam int C_RPPB = ru(TRPPB_PS);
  localparam int C_RPAB = ru(TRPAB_PS);
  localparam int C_RTW = RL + ru(TDQSCK_PS) + BL / 2 + 1 - WL;
  localparam int C_WTR = WL + 1 + BL / 2 + ru(TWTR_PS);
  localparam int C_WR = WL + BL / 2 + 1 + ru(TWR_PS);
  localparam int C_CCD = BL / 2;
  localparam int LINK_DIV = 4;
  localparam int CW = 8;
  typedef logic [CW-1:0] lpbc_cnt_t;
  typedef struct packed {
    logic cs_n;
    logic [9:0] ca_r;
    logic [9:0] ca_f;
  } lpbc_ca_t;
  typedef struct packed {
    logic [3:0] op;
    logic [2:0] bank;
    logic all_banks_flag;
    logic [3:0] byte_write_mask;
    logic [15:0] addr;
    logic [31:0] wdata;
  } lpbc_req_t;
endpackage

// ### hw/lpbc_bank_timer.sv
// one bank's open state and earliest-command counters
`timescale 1ns/1ps
module lpbc_bank_timer
  import lpbc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_tick,
  input wire logic i_act,
  input wire logic i_col,
  input wire logic i_wr,
  input wire logic i_pre,
  input wire logic i_pre_all,
  output logic o_open,
  output logic o_act_ok,
  output logic o_col_ok,
  output logic o_pre_ok
);
  typedef struct packed {
    logic open;
    lpbc_cnt_t rcd;
    lpbc_cnt_t rc;
    lpbc_cnt_t rp;
    lpbc_cnt_t wr;
  } lpbc_bank_t;
  lpbc_bank_t s_q;
  lpbc_bank_t s_d;
  function automatic lpbc_cnt_t dec(input lpbc_cnt_t c);
    return (c == '0) ? c : c - lpbc_cnt_t'(1);
  endfunction
  always_comb begin
    s_d = s_q;
    if (i_tick) begin
      s_d.rcd = dec(s_q.rcd);
      s_d.rc = dec(s_q.rc);
      s_d.rp = dec(s_q.rp);
      s_d.wr = dec(s_q.wr);
      if (i_act) begin
        s_d.open = 1'b1;
        s_d.rcd = lpbc_cnt_t'(C_RCD);
        s_d.rc = lpbc_cnt_t'(C_RC);
      end
      if (i_col && i_wr) begin
        s_d.wr = lpbc_cnt_t'(C_WR);
      end
      if (i_pre) begin
        s_d.open = 1'b0;
        s_d.rp = lpbc_cnt_t'(i_pre_all ? C_RPAB : C_RPPB);
      end
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign o_open = s_q.open;
  assign o_act_ok = !s_q.open && s_q.rc == '0 && s_q.rp == '0;
  assign o_col_ok = s_q.open && s_q.rcd == '0;
  assign o_pre_ok = s_q.wr == '0;
endmodule

// ### hw/lpbc_ctrl.sv
// host controller: avalon registers in, ca/dq/dqs/dm pins out to the dram
`timescale 1ns/1ps
module lpbc_ctrl
  import lpbc_pkg::*;
#(
  parameter int DQ_BYTES = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_ck,
  output lpbc_ca_t o_ca,
  output logic o_cs_n,
  output logic [9:0] o_ca_pins,
  output logic [DQ_BYTES*8-1:0] o_dq,
  output logic o_dq_oe,
  input wire logic [DQ_BYTES*8-1:0] i_dq,
  output logic o_dqs,
  output logic o_dqs_oe,
  input wire logic i_dqs,
  output logic [DQ_BYTES-1:0] o_byte_write_mask
);
  if (DQ_BYTES < 1 || DQ_BYTES > 4) begin : g_chk_bytes
    $error("DQ_BYTES must be 1 to 4");
  end
  // spacing counters are CW bits wide and saturate at zero, so a longer figure would wrap
  if (C_RC > (2 ** CW) - 1 || C_FAW > (2 ** CW) - 1 || C_WR > (2 ** CW) - 1) begin : g_chk_cnt
    $error("spacing count exceeds counter width");
  end
  if (RL > 5'h1F || WL > 5'h1F) begin : g_chk_lat
    $error("latency exceeds burst delay counter");
  end
  // the divider is two bits and the link clock is high for the first half of it
  if (LINK_DIV < 2 || LINK_DIV > 4 || LINK_DIV % 2 != 0) begin : g_chk_div
    $error("link divider must be 2 or 4");
  end
  localparam int DW = DQ_BYTES * 8;
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_RISE, ST_FALL, ST_DONE} lpbc_st_t;
  typedef struct packed {
    lpbc_st_t st;
    lpbc_req_t req;
    logic busy;
    logic err;
    logic training;
    logic [1:0] div;
    logic ck;
    lpbc_ca_t ca;
    lpbc_cnt_t rrd;
    lpbc_cnt_t ccd;
    lpbc_cnt_t rtw;
    lpbc_cnt_t wtr;
    lpbc_cnt_t [FAW_ACTS-1:0] faw;
    logic [3:0] beat;
    logic [4:0] dly;
    logic rd_run;
    logic wr_run;
    // burst data and mask are frozen at issue; software may load the next command meanwhile
    logic [31:0] wbuf;
    logic [3:0] wmask;
    logic [31:0] rdata;
    logic [31:0] avs_rd;
    logic avs_ack;
    logic [1:0] dqs_sync;
    logic dqs_prev;
  } lpbc_state_t;
  lpbc_state_t s_q;
  lpbc_state_t s_d;
  logic tick;
  logic [NUM_BANKS-1:0] b_act, b_col, b_pre, b_open, b_act_ok, b_col_ok, b_pre_ok;
  logic pre_all;
  logic faw_ok;
  logic issue_ok;
  function automatic lpbc_cnt_t dec(input lpbc_cnt_t c);
    return (c == '0) ? c : c - lpbc_cnt_t'(1);
  endfunction
  // the dram clock is a divided system clock; commands change while it is low, one system clock before its rising edge
  assign tick = s_q.div == 2'(LINK_DIV - 1);
  assign pre_all = s_q.req.all_banks_flag;
  always_comb begin
    faw_ok = 1'b0;
    for (int i = 0; i < FAW_ACTS; i++) begin
      if (s_q.faw[i] == '0) faw_ok = 1'b1;
    end
  end
  always_comb begin
    b_act = '0;
    b_col = '0;
    b_pre = '0;
    if (tick && s_q.st == ST_RISE) begin
      if (s_q.req.op == OP_ACT) b_act[s_q.req.bank] = 1'b1;
      if (s_q.req.op == OP_RD || s_q.req.op == OP_WR) b_col[s_q.req.bank] = 1'b1;
      if (s_q.req.op == OP_PRE) begin
        if (pre_all) b_pre = '1;
        else b_pre[s_q.req.bank] = 1'b1;
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      lpbc_bank_timer u_bank (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_tick(tick),
        .i_act(b_act[g]),
        .i_col(b_col[g]),
        .i_wr(s_q.req.op == OP_WR),
        .i_pre(b_pre[g]),
        .i_pre_all(pre_all),
        .o_open(b_open[g]),
        .o_act_ok(b_act_ok[g]),
        .o_col_ok(b_col_ok[g]),
        .o_pre_ok(b_pre_ok[g])
      );
    end
  endgenerate
  always_comb begin
    issue_ok = 1'b0;
    case (s_q.req.op)
      OP_ACT: issue_ok = b_act_ok[s_q.req.bank] && s_q.rrd == '0 && faw_ok;
      // one burst engine: a column command waits for the running burst, trading gapless streams for
      // a single data path
      OP_RD: issue_ok = b_col_ok[s_q.req.bank] && s_q.ccd == '0 && s_q.wtr == '0 && !s_q.rd_run && !s_q.wr_run;
      OP_WR: issue_ok = b_col_ok[s_q.req.bank] && s_q.ccd == '0 && s_q.rtw == '0 && !s_q.rd_run && !s_q.wr_run;
      OP_PRE: issue_ok = pre_all ? (&b_pre_ok) : b_pre_ok[s_q.req.bank];
      default: issue_ok = !s_q.rd_run && !s_q.wr_run;
    endcase
  end
  always_comb begin
    logic hit;
    hit = 1'b0;
    s_d = s_q;
    s_d.avs_ack = 1'b0;
    s_d.div = (tick) ? 2'b00 : s_q.div + 2'b01;
    s_d.ck = s_q.div < 2'(LINK_DIV / 2);
    s_d.dqs_sync = {s_q.dqs_sync[0], i_dqs};
    s_d.dqs_prev = s_q.dqs_sync[1];
    // avalon slave: one wait cycle, answer from a register
    if ((i_avs_read || i_avs_write) && !s_q.avs_ack) begin
      s_d.avs_ack = 1'b1;
      s_d.avs_rd = RDATA_UNMAPPED;
      if (i_avs_write) begin
        if (i_avs_address == REG_CMD && !s_q.busy) begin
          s_d.req.op = i_avs_writedata[CMD_OP_LSB +: 4];
          s_d.req.bank = i_avs_writedata[CMD_BANK_LSB +: 3];
          s_d.req.byte_write_mask = i_avs_writedata[CMD_MASK_LSB +: 4];
          s_d.req.all_banks_flag = i_avs_writedata[CMD_AB_BIT];
          if (i_avs_writedata[CMD_GO_BIT]) begin
            s_d.busy = 1'b1;
            s_d.err = 1'b0;
            s_d.st = ST_WAIT;
          end
        end else if (i_avs_address == REG_ADDR) begin
          s_d.req.addr = i_avs_writedata[15:0];
        end else if (i_avs_address == REG_WDATA) begin
          s_d.req.wdata = i_avs_writedata;
        end
      end else begin
        if (i_avs_address == REG_STATUS) begin
          s_d.avs_rd = {13'h0000, s_q.training, s_q.err, s_q.busy, 8'h00, b_open};
        end else if (i_avs_address == REG_WDATA) begin
          s_d.avs_rd = s_q.rdata;
        end else if (i_avs_address == REG_CMD) begin
          s_d.avs_rd = {s_q.busy, 18'h00000, s_q.req.all_banks_flag, s_q.req.byte_write_mask,
            1'b0, s_q.req.bank, s_q.req.op};
        end
      end
    end
    if (tick) begin
      s_d.rrd = dec(s_q.rrd);
      s_d.ccd = dec(s_q.ccd);
      s_d.rtw = dec(s_q.rtw);
      s_d.wtr = dec(s_q.wtr);
      for (int i = 0; i < FAW_ACTS; i++) s_d.faw[i] = dec(s_q.faw[i]);
      s_d.ca.cs_n = 1'b1;
      if (s_q.st == ST_FALL) s_d.st = ST_DONE;
      if (s_q.st == ST_DONE) begin
        s_d.st = ST_IDLE;
        s_d.busy = 1'b0;
      end
      // burst data phase: counts whole link clocks from the column command
      if (s_q.rd_run || s_q.wr_run) begin
        if (s_q.dly != '0) s_d.dly = s_q.dly - 5'd1;
        else if (s_q.beat == 4'(BL / 2 - 1)) begin
          s_d.rd_run = 1'b0;
          s_d.wr_run = 1'b0;
        end else s_d.beat = s_q.beat + 4'd1;
      end
    end
    // a read beat is caught on the synchronised rising strobe
    if (s_q.rd_run && s_q.dly == '0 && s_q.dqs_sync[1] && !s_q.dqs_prev) begin
      s_d.rdata = 32'(i_dq);
    end
    case (s_q.st)
      ST_IDLE: begin
      end
      ST_WAIT: begin
        if (s_q.req.op == OP_MRW) begin
          case (s_q.req.addr[7:0])
            MA_REFRESH_BANK_MASK: hit = 1'b1;
            MA_REFRESH_SEGMENT_MASK: hit = 1'b1;
            MA_TRAINING_ENTER_A: hit = 1'b1;
            MA_TRAINING_ENTER_B: hit = 1'b1;
            MA_TRAINING_EXIT: hit = 1'b1;
            MA_SOFT_RESET: hit = 1'b1;
            default: hit = 1'b0;
          endcase
          if (!hit) begin
            s_d.err = 1'b1;
            s_d.busy = 1'b0;
            s_d.st = ST_IDLE;
          end
        end else if (!(s_q.req.op inside {OP_ACT, OP_RD, OP_WR, OP_PRE})) begin
          s_d.err = 1'b1;
          s_d.busy = 1'b0;
          s_d.st = ST_IDLE;
        end
        if (tick && issue_ok && s_d.st == ST_WAIT) begin
          s_d.st = ST_RISE;
        end
      end
      ST_RISE: begin
        if (tick) begin
          s_d.ca.cs_n = 1'b0;
          s_d.ca.ca_r = '0;
          s_d.ca.ca_f = '0;
          case (s_q.req.op)
            OP_ACT: begin
              // bank bits sit on ca9-ca7 as in every other bank command
              s_d.ca.ca_r = {s_q.req.bank, s_q.req.addr[12:8], CA_ACT[1:0]};
              s_d.ca.ca_f = s_q.req.addr[9:0];
              s_d.rrd = lpbc_cnt_t'(C_RRD);
              for (int i = FAW_ACTS - 1; i > 0; i--) s_d.faw[i] = dec(s_q.faw[i - 1]);
              s_d.faw[0] = lpbc_cnt_t'(C_FAW);
            end
            OP_RD, OP_WR: begin
              s_d.ca.ca_r = {s_q.req.bank, s_q.req.addr[2:1], 2'b00,
                (s_q.req.op == OP_RD) ? CA_RD[2:0] : CA_WR[2:0]};
              s_d.ca.ca_f = {s_q.req.addr[10:3], 2'b00};
              s_d.ccd = lpbc_cnt_t'(C_CCD);
              s_d.beat = '0;
              if (s_q.req.op == OP_RD) begin
                s_d.rd_run = 1'b1;
                s_d.dly = 5'(RL);
                s_d.rtw = lpbc_cnt_t'(C_RTW);
              end else begin
                s_d.wr_run = 1'b1;
                s_d.dly = 5'(WL);
                s_d.wtr = lpbc_cnt_t'(C_WTR);
                s_d.wbuf = s_q.req.wdata;
                s_d.wmask = s_q.req.byte_write_mask;
              end
            end
            OP_PRE: begin
              s_d.ca.ca_r = {s_q.req.bank, 2'b00, s_q.req.all_banks_flag, CA_PRE};
            end
            default: begin
              s_d.ca.ca_r = {s_q.req.addr[5:0], CA_MRW};
              s_d.ca.ca_f = {s_q.req.wdata[7:0], s_q.req.addr[7:6]};
              if (s_q.req.addr[7:0] == MA_TRAINING_EXIT) s_d.training = 1'b0;
              else if (s_q.req.addr[7:0] inside {MA_TRAINING_ENTER_A, MA_TRAINING_ENTER_B}) begin
                s_d.training = 1'b1;
              end
            end
          endcase
          s_d.st = ST_FALL;
        end
      end
      default: begin
      end
    endcase
  end
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
      s_q.ca.cs_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  // one wait state: a request is taken on its first edge and answered on the next
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !s_q.avs_ack;
  assign o_avs_readdata = s_q.avs_rd;
  assign o_ck = s_q.ck;
  assign o_ca = s_q.ca;
  assign o_cs_n = s_q.ca.cs_n;
  assign o_ca_pins = s_q.ck ? s_q.ca.ca_r : s_q.ca.ca_f;
  // strobe toggles with the link clock during the burst; write data holds the one wbuf word throughout
  assign o_dq_oe = s_q.wr_run && s_q.dly == '0;
  assign o_dq = DW'(s_q.wbuf);
  assign o_dqs_oe = s_q.wr_run && s_q.dly <= 5'd1;
  assign o_dqs = (s_q.dly == '0) ? s_q.ck : 1'b0;
  assign o_byte_write_mask = s_q.wmask[DQ_BYTES-1:0];
endmodule

// ### verif/lpbc_ctrl_properties.sv
// checker: command spacing, pin framing and bus handshake of the dram controller
`timescale 1ns/1ps
module lpbc_ctrl_properties
  import lpbc_pkg::*;
#(
  parameter int DQ_BYTES = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic o_ck,
  input wire lpbc_ca_t o_ca,
  input wire logic o_cs_n,
  input wire logic [9:0] o_ca_pins,
  input wire logic o_dq_oe
);
  localparam int OE_LO = (WL - 2) * LINK_DIV;
  localparam int OE_HI = (WL + 2) * LINK_DIV;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  logic ck_q;
  logic [7:0] opn;
  int lk, t_any, t_rd, t_wr, t_col;
  int t_h [4];
  int t_act [8];
  int t_pre [8];
  int t_wb [8];
  int rpn [8];
  wire rise = o_ck & !ck_q;
  wire cmd = rise & !o_ca.cs_n;
  wire [2:0] bk = o_ca.ca_r[9:7];
  wire act = cmd && o_ca.ca_r[1:0] == CA_ACT[1:0];
  wire col = cmd && o_ca.ca_r[1:0] == CA_RD[1:0];
  wire rd = col && o_ca.ca_r[2];
  wire wr = col && !o_ca.ca_r[2];
  wire pre = cmd && o_ca.ca_r[3:0] == CA_PRE;
  // link-clock timestamps; reset leaves every gap far beyond any limit
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ck_q <= 1'h0;
      lk <= 1000;
      opn <= 8'h00;
      {t_any, t_rd, t_wr, t_col} <= '0;
      t_h <= '{default: 0};
      t_act <= '{default: 0};
      t_pre <= '{default: 0};
      t_wb <= '{default: 0};
      rpn <= '{default: 0};
    end else begin
      ck_q <= o_ck;
      if (rise) lk <= lk + 1;
      if (act) begin
        opn[bk] <= 1'h1;
        t_act[bk] <= lk;
        t_any <= lk;
        t_h <= '{lk, t_h[0], t_h[1], t_h[2]};
      end
      if (col) t_col <= lk;
      if (rd) t_rd <= lk;
      if (wr) begin
        t_wr <= lk;
        t_wb[bk] <= lk;
      end
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (pre && (o_ca.ca_r[4] || b == int'(bk))) begin
          opn[b] <= 1'h0;
          t_pre[b] <= lk;
          rpn[b] <= o_ca.ca_r[4] ? C_RPAB : C_RPPB;
        end
      end
    end
  end
  sequence s_wburst;
    o_dq_oe [*8] ##1 o_dq_oe [*8];
  endsequence
  AST_ONE_WAIT: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest longer than one cycle");
  AST_CA_PINS: assert property (o_cs_n == o_ca.cs_n && o_ca_pins == (o_ck ? o_ca.ca_r : o_ca.ca_f))
    else $error("ca pins disagree with command");
  AST_RCD: assert property (col |-> opn[bk] && lk - t_act[bk] >= C_RCD)
    else $error("column access too soon or to idle bank");
  AST_RC: assert property (act |-> !opn[bk] && lk - t_act[bk] >= C_RC)
    else $error("activate to open bank or inside tRC");
  AST_RRD: assert property (act |-> lk - t_any >= C_RRD)
    else $error("activates closer than tRRD");
  AST_FAW: assert property (act |-> lk - t_h[3] >= C_FAW)
    else $error("fifth activate inside tFAW");
  AST_RP: assert property (act |-> lk - t_pre[bk] >= rpn[bk])
    else $error("activate inside precharge time");
  AST_RTW: assert property (wr |-> lk - t_rd >= C_RTW)
    else $error("write too soon after read");
  AST_WTR: assert property (rd |-> lk - t_wr >= C_WTR)
    else $error("read too soon after write");
  AST_CCD: assert property (col |-> lk - t_col >= C_CCD)
    else $error("burst cut by next column access");
  AST_TWR: assert property (pre |-> lk - (o_ca.ca_r[4] ? t_wr : t_wb[bk]) >= C_WR)
    else $error("precharge inside write recovery");
  AST_WDATA: assert property (wr |-> ##[OE_LO:OE_HI] o_dq_oe)
    else $error("write data not driven after write latency");
  AST_WBURST: assert property ($rose(o_dq_oe) |-> s_wburst)
    else $error("write burst shorter than four link clocks");
endmodule

bind lpbc_ctrl lpbc_ctrl_properties #(.DQ_BYTES(DQ_BYTES)) u_props (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .o_ck(o_ck),
  .o_ca(o_ca), .o_cs_n(o_cs_n), .o_ca_pins(o_ca_pins), .o_dq_oe(o_dq_oe));

// ### verif/lpbc_dram_model.sv
// behavioural dram: command decode, bank state, burst data and mode registers
`timescale 1ns/1ps
module lpbc_dram_model
  import lpbc_pkg::*;
#(
  parameter int DQ_BYTES = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_ck,
  input wire lpbc_ca_t i_ca,
  input wire logic [DQ_BYTES*8-1:0] i_dq,
  input wire logic i_dqs,
  input wire logic i_dqs_oe,
  input wire logic [DQ_BYTES-1:0] i_mask,
  output logic [DQ_BYTES*8-1:0] o_dq,
  output logic o_dqs,
  output logic o_training,
  output logic [7:0] o_open
);
  logic [DQ_BYTES*8-1:0] mem [logic [13:0]];
  logic [DQ_BYTES*8-1:0] rq_w [$];
  logic [DQ_BYTES*8-1:0] word = '0;
  logic [DQ_BYTES*8-1:0] nw;
  int rq_t [$];
  logic [13:0] wq [$];
  logic [7:0] bank_mask = 8'h00;
  logic [7:0] seg_mask = 8'h00;
  logic ck_q = 1'h0;
  logic dqs_q = 1'h0;
  int t = 0;
  int ph = 20;
  int nb = 0;
  wire [2:0] bk = i_ca.ca_r[9:7];
  wire [13:0] key = {bk, i_ca.ca_f[9:1], i_ca.ca_r[6:5]};
  wire [7:0] ma = {i_ca.ca_f[1:0], i_ca.ca_r[9:4]};
  initial o_training = 1'h0;
  initial o_open = 8'h00;
  // strobe rests low so that no phantom edge reaches the read capture
  assign o_dqs = ph >= 2 && ph < 18 && ph[1];
  assign o_dq = ph < 20 ? word : ~word;
  always @(posedge i_clk_sys) begin
    ck_q <= i_ck;
    dqs_q <= i_dqs;
    t <= t + 1;
    if (ph < 20) ph <= ph + 1;
    if (rq_t.size() > 0 && rq_t[0] <= t) begin
      ph <= 0;
      word <= rq_w.pop_front();
      void'(rq_t.pop_front());
    end
    if (i_ck && !ck_q && !i_ca.cs_n) begin
      if (i_ca.ca_r[1:0] == CA_ACT[1:0]) o_open[bk] <= 1'h1;
      else if (i_ca.ca_r[2:0] == CA_RD[2:0]) begin
        rq_t.push_back(t + RL * LINK_DIV - 2);
        rq_w.push_back(mem.exists(key) ? mem[key] : '0);
      end else if (i_ca.ca_r[2:0] == CA_WR[2:0]) wq.push_back(key);
      else if (i_ca.ca_r[3:0] == CA_PRE) o_open <= i_ca.ca_r[4] ? 8'h00 : o_open & ~(8'h01 << bk);
      else if (i_ca.ca_r[3:0] == CA_MRW) begin
        case (ma)
          MA_REFRESH_BANK_MASK: bank_mask <= i_ca.ca_f[9:2];
          MA_REFRESH_SEGMENT_MASK: seg_mask <= i_ca.ca_f[9:2];
          MA_TRAINING_ENTER_A, MA_TRAINING_ENTER_B: o_training <= 1'h1;
          MA_TRAINING_EXIT: o_training <= 1'h0;
          MA_CAL_PATTERN_A, MA_CAL_PATTERN_B: ; // pattern registers are read-only, a write leaves them
          default: ;
        endcase
      end
    end
    if (i_dqs_oe && i_dqs != dqs_q && wq.size() > 0) begin
      nw = mem.exists(wq[0]) ? mem[wq[0]] : '0;
      for (int b = 0; b < DQ_BYTES; b++) begin
        if (!i_mask[b]) nw[b*8 +: 8] = i_dq[b*8 +: 8];
      end
      mem[wq[0]] = nw;
      nb = nb + 1;
      if (nb == BL) begin
        nb = 0;
        void'(wq.pop_front());
      end
    end
  end
endmodule

// ### verif/test_lpbc_ctrl.sv
// testbench: register-driven dram commands against the behavioural dram
`timescale 1ns/1ps
module test_lpbc_ctrl
  import lpbc_pkg::*;
;
  logic i_clk_sys = 1'h0;
  logic i_arst_n = 1'h0;
  logic [3:0] av_a = 4'h0;
  logic av_r = 1'h0;
  logic av_w = 1'h0;
  logic [31:0] av_d = 32'h0;
  logic [31:0] rdata, q, dq, m_dq;
  logic wreq, ck, cs_n, dq_oe, dqs, dqs_oe, m_dqs, train;
  lpbc_ca_t ca;
  logic [9:0] pins;
  logic [3:0] msk;
  logic [7:0] m_open;
  logic [7:0] ma_tab [4] = '{MA_TRAINING_ENTER_A, MA_TRAINING_EXIT, MA_TRAINING_ENTER_B, MA_TRAINING_EXIT};
  int failures = 0;
  int n_compared = 0;
  wire [31:0] dq_w = dq_oe ? dq : m_dq;
  wire dqs_w = dqs_oe ? dqs : m_dqs;
  always #4 i_clk_sys = ~i_clk_sys;
  lpbc_ctrl #(.DQ_BYTES(4)) DUT (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_avs_address(av_a),
    .i_avs_read(av_r), .i_avs_write(av_w), .i_avs_writedata(av_d), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_ck(ck), .o_ca(ca), .o_cs_n(cs_n), .o_ca_pins(pins), .o_dq(dq),
    .o_dq_oe(dq_oe), .i_dq(dq_w), .o_dqs(dqs), .o_dqs_oe(dqs_oe), .i_dqs(dqs_w), .o_byte_write_mask(msk));
  lpbc_dram_model #(.DQ_BYTES(4)) u_dram (.i_clk_sys(i_clk_sys), .i_ck(ck), .i_ca(ca), .i_dq(dq_w),
    .i_dqs(dqs_w), .i_dqs_oe(dqs_oe), .i_mask(msk), .o_dq(m_dq), .o_dqs(m_dqs), .o_training(train),
    .o_open(m_open));
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // avalon transfer: held until waitrequest is seen low at a rising edge
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    av_a <= a;
    av_d <= d;
    av_w <= w;
    av_r <= !w;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (wreq !== 1'h0 && n < 100);
    q = rdata;
    av_w <= 1'h0;
    av_r <= 1'h0;
    if (n >= 100) begin
      failures++;
      give_verdict();
    end
    @(posedge i_clk_sys);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [2:0] bk, input logic [3:0] m, input logic ab,
                     input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    av(1'h1, REG_ADDR, {16'h0000, a});
    av(1'h1, REG_WDATA, d);
    av(1'h1, REG_CMD, 32'h8000_0000 | {19'h0, ab, m, 1'h0, bk, op});
    do begin
      av(1'h0, REG_STATUS, 32'h0);
      n++;
    end while (q[16] !== 1'h0 && n < 200);
    if (n >= 200) begin
      failures++;
      give_verdict();
    end
  endtask
  task automatic read_back(input logic [31:0] exp);
    repeat ((RL + BL) * LINK_DIV + 16) @(posedge i_clk_sys);
    av(1'h0, REG_WDATA, 32'h0);
    chk(q, exp);
  endtask
  task automatic open_is(input logic [7:0] exp);
    av(1'h0, REG_STATUS, 32'h0);
    chk({24'h0, q[7:0]}, {24'h0, exp});
    chk({24'h0, m_open}, {24'h0, exp});
  endtask
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_arst_n <= 1'h1;
    @(posedge i_clk_sys);
    av(1'h0, REG_STATUS, 32'h0);
    chk(q, 32'h0);
    av(1'h0, 4'h2, 32'h0);
    chk(q, RDATA_UNMAPPED);
    for (int b = 0; b < 5; b++) cmd(OP_ACT, b[2:0], 4'h0, 1'h0, 16'h0100, 32'h0);
    open_is(8'h1F);
    cmd(OP_WR, 3'h0, 4'h0, 1'h0, 16'h0010, 32'hA1A2_A3A4);
    cmd(OP_WR, 3'h1, 4'h0, 1'h0, 16'h0010, 32'hB1B2_B3B4);
    cmd(OP_WR, 3'h0, 4'h5, 1'h0, 16'h0010, 32'hC1C2_C3C4);
    cmd(OP_RD, 3'h0, 4'h0, 1'h0, 16'h0010, 32'h0);
    read_back(32'hC1A2_C3A4);
    cmd(OP_RD, 3'h1, 4'h0, 1'h0, 16'h0010, 32'h0);
    cmd(OP_WR, 3'h1, 4'h0, 1'h0, 16'h0020, 32'hD1D2_D3D4);
    read_back(32'hB1B2_B3B4);
    cmd(OP_RD, 3'h0, 4'h0, 1'h0, 16'h0010, 32'h0);
    cmd(OP_RD, 3'h1, 4'h0, 1'h0, 16'h0020, 32'h0);
    read_back(32'hD1D2_D3D4);
    cmd(OP_PRE, 3'h0, 4'h0, 1'h0, 16'h0000, 32'h0);
    open_is(8'h1E);
    cmd(OP_PRE, 3'h6, 4'h0, 1'h1, 16'h0000, 32'h0);
    open_is(8'h00);
    cmd(OP_ACT, 3'h0, 4'h0, 1'h0, 16'h0200, 32'h0);
    open_is(8'h01);
    for (int i = 0; i < 4; i++) begin
      cmd(OP_MRW, 3'h0, 4'h0, 1'h0, {8'h00, ma_tab[i]}, 32'h0000_0055);
      av(1'h0, REG_STATUS, 32'h0);
      chk({31'h0, q[18]}, {31'h0, !i[0]});
    end
    cmd(OP_MRW, 3'h0, 4'h0, 1'h0, 16'h0012, 32'h0000_0055);
    av(1'h0, REG_STATUS, 32'h0);
    chk({31'h0, q[17]}, 32'h1);
    give_verdict();
  end
endmodule
